// File: rtl/two_wire_ctrl.sv
// Overview of operation
// - Start request drives a Start condition, then clears itself.
// - Repeated start request drives a Repeated Start, then clears itself.
// - Stop request drives a Stop condition, then clears itself.
// - Receive request clocks in one byte, clears after the eighth bit.
// - Acknowledge request drives one acknowledge cycle, then clears itself.
// - Acknowledge value one sends NACK, zero sends ACK.
// - Module on gives the block both pins; off releases them.
// - Halt in idle stops the block while the processor idles.
// - With stretching, clock release bit holds or frees clock; hardware clears it.
// - Without stretching, only release writes count; cleared at slave send start.
// - Accept all addresses makes the slave acknowledge every non-reserved address.
// - Ten bit select compares own address as ten or seven bits.
// - General call accept makes the slave acknowledge address zero.
// - Set mask bits make that address position match either value.
// - Reserved addresses never match, whatever the mask.
// - Pattern 11110xx matches only as a ten bit upper byte or with accept all addresses.
// - Bus clock is pclk over reload plus one plus pclk/10MHz, rounded down to an even count.
// - Acknowledge seen flag updates at the end of each acknowledge after a master send.
// - Mask register holds ten bits, one per address bit.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"

module two_wire_ctrl #(
  parameter int RW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_idle,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [9:0] own_r;
  logic [9:0] mask_r;
  logic [RW-1:0] reload_r;
  logic [7:0] txd_r;
  logic [7:0] rxd_r;
  logic rx_full_r;
  logic ack_seen_r;
  logic send_req_r;
  logic on;
  logic run;
  logic [31:0] rd_val;
  logic mapped;
  logic wr;
  logic rd_rxd;

  brg_if #(.RW(RW)) bi ();

  tw_pkg::mst_t mst_r;
  tw_pkg::slv_t sl_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic msda_r;
  logic mscl_r;
  logic msda_d_r;
  logic [7:0] mshift_r;
  logic last;
  logic m_done;
  logic m_ld_r;
  logic [15:0] clr_mask;

  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] receive_shift_reg;
  logic [7:0] sl_tx_r;
  logic [3:0] cnt_r;
  logic sl_rw_r;
  logic sl_hit10_r;
  logic sl_data_r;
  logic ack_drv_r;
  logic rel_clr_r;
  logic sl_ld_r;
  logic start_det;
  logic stop_det;
  logic rise;
  logic fall;
  logic [9:0] m_eff;
  logic [7:0] byte_in;
  logic reserved;
  logic gcall;
  logic hit7;
  logic hit_up;
  logic hit_lo;
  logic ack_adr;

  assign on = ctrl_r[`B_ON];
  assign run = on & ~(cpu_idle & ctrl_r[`B_SIDL]);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign wr = psel & penable & pready & pwrite & mapped;
  assign rd_rxd = psel & penable & pready & ~pwrite & (paddr == `OFS_RXD);

  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    case (paddr)
      `OFS_CTRL: rd_val[15:0] = ctrl_r;
      `OFS_STAT: begin
        rd_val[`S_ACK] = ack_seen_r;
        rd_val[`S_SEND] = (mst_r == tw_pkg::M_SEND);
        rd_val[`S_MBUSY] = (mst_r != tw_pkg::M_IDLE);
        rd_val[`S_DATA] = sl_data_r;
        rd_val[`S_RW] = sl_rw_r;
        rd_val[`S_FULL] = rx_full_r;
      end
      `OFS_OWN: rd_val[9:0] = own_r;
      `OFS_MASK: rd_val[9:0] = mask_r;
      `OFS_RELOAD: rd_val[RW-1:0] = reload_r;
      `OFS_TXD: rd_val[7:0] = txd_r;
      `OFS_RXD: rd_val[7:0] = rxd_r;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RST;
    end else if (wr && paddr == `OFS_CTRL) begin
      ctrl_r <= pwdata[15:0] & `CTRL_WMASK;
      if (!ctrl_r[`B_STRETCH] && !pwdata[`B_REL]) begin
        ctrl_r[`B_REL] <= ctrl_r[`B_REL];
      end
    end else begin
      ctrl_r <= ctrl_r & ~clr_mask;
      if (rel_clr_r) begin
        ctrl_r[`B_REL] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_r <= '0;
      mask_r <= '0;
      reload_r <= '0;
      txd_r <= '0;
    end else if (wr) begin
      if (paddr == `OFS_OWN) own_r <= pwdata[9:0];
      if (paddr == `OFS_MASK) mask_r <= pwdata[9:0];
      if (paddr == `OFS_RELOAD) reload_r <= pwdata[RW-1:0];
      if (paddr == `OFS_TXD) txd_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_r <= '0;
      rx_full_r <= 1'b0;
    end else if (m_ld_r || sl_ld_r) begin
      rxd_r <= m_ld_r ? mshift_r : receive_shift_reg;
      rx_full_r <= 1'b1;
    end else if (rd_rxd) begin
      rx_full_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  assign bi.reload = reload_r;
  assign bi.run = run & (mst_r != tw_pkg::M_IDLE);

  half_period_gen #(.RW(RW)) u_gen (
    .pclk(pclk),
    .presetn(presetn),
    .bi(bi)
  );

  always_comb begin
    last = 1'b0;
    clr_mask = '0;
    unique case (mst_r)
      tw_pkg::M_IDLE: last = 1'b0;
      tw_pkg::M_START: begin
        last = (ph_r == 2'h2);
        clr_mask[`B_START] = 1'b1;
      end
      tw_pkg::M_RSTART: begin
        last = (ph_r == 2'h3);
        clr_mask[`B_RSTART] = 1'b1;
      end
      tw_pkg::M_STOP: begin
        last = (ph_r == 2'h2);
        clr_mask[`B_STOP] = 1'b1;
      end
      tw_pkg::M_RECV: begin
        last = (ph_r == 2'h1) && (bit_r == 4'h7);
        clr_mask[`B_RECV] = 1'b1;
      end
      tw_pkg::M_ACK: begin
        last = (ph_r == 2'h2);
        clr_mask[`B_ACKGO] = 1'b1;
      end
      tw_pkg::M_SEND: last = (ph_r == 2'h1) && (bit_r == 4'h8);
      default: last = 1'b0;
    endcase
    m_done = run & bi.tick & last;
    if (!m_done) clr_mask = '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_req_r <= 1'b0;
    end else if (wr && paddr == `OFS_TXD
                 && (sl_r == tw_pkg::S_IDLE || sl_r == tw_pkg::S_ADR1)) begin
      send_req_r <= 1'b1;
    end else if (mst_r == tw_pkg::M_SEND || !on) begin
      send_req_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_r <= tw_pkg::M_IDLE;
      ph_r <= '0;
      bit_r <= '0;
      msda_r <= 1'b1;
      mscl_r <= 1'b1;
      mshift_r <= '0;
      m_ld_r <= 1'b0;
      ack_seen_r <= 1'b0;
    end else if (!on) begin
      mst_r <= tw_pkg::M_IDLE;
      msda_r <= 1'b1;
      mscl_r <= 1'b1;
      m_ld_r <= 1'b0;
    end else if (run) begin
      m_ld_r <= m_done && mst_r == tw_pkg::M_RECV;
      ph_r <= (m_done || mst_r == tw_pkg::M_IDLE) ? 2'h0 : ph_r + (bi.tick ? 2'h1 : 2'h0);
      if (m_done) begin
        mst_r <= tw_pkg::M_IDLE;
        if (mst_r == tw_pkg::M_SEND) begin
          ack_seen_r <= sda_in;
          msda_r <= 1'b1;
          mscl_r <= 1'b0;
        end
        if (mst_r == tw_pkg::M_RECV) begin
          mshift_r <= {mshift_r[6:0], sda_in};
          mscl_r <= 1'b0;
        end
      end else unique case (mst_r)
        tw_pkg::M_IDLE: begin
          bit_r <= '0;
          if (ctrl_r[`B_START]) begin
            mst_r <= tw_pkg::M_START;
            msda_r <= 1'b1;
            mscl_r <= 1'b1;
          end else if (ctrl_r[`B_RSTART]) begin
            mst_r <= tw_pkg::M_RSTART;
            msda_r <= 1'b1;
            mscl_r <= 1'b0;
          end else if (ctrl_r[`B_STOP]) begin
            mst_r <= tw_pkg::M_STOP;
            msda_r <= 1'b0;
            mscl_r <= 1'b0;
          end else if (ctrl_r[`B_RECV]) begin
            mst_r <= tw_pkg::M_RECV;
            msda_r <= 1'b1;
            mscl_r <= 1'b0;
          end else if (ctrl_r[`B_ACKGO]) begin
            mst_r <= tw_pkg::M_ACK;
            msda_r <= ctrl_r[`B_ACKVAL];
            mscl_r <= 1'b0;
          end else if (send_req_r) begin
            mst_r <= tw_pkg::M_SEND;
            mshift_r <= txd_r;
            msda_r <= txd_r[7];
            mscl_r <= 1'b0;
          end
        end
        tw_pkg::M_START: if (bi.tick) begin
          if (ph_r == 2'h0) msda_r <= 1'b0;
          else mscl_r <= 1'b0;
        end
        tw_pkg::M_RSTART: if (bi.tick) begin
          if (ph_r == 2'h1) msda_r <= 1'b0;
          else mscl_r <= (ph_r == 2'h0);
        end
        tw_pkg::M_STOP: if (bi.tick) begin
          if (ph_r == 2'h0) mscl_r <= 1'b1;
          else msda_r <= 1'b1;
        end
        tw_pkg::M_ACK: if (bi.tick) mscl_r <= (ph_r == 2'h0);
        tw_pkg::M_RECV: if (bi.tick) begin
          mscl_r <= (ph_r == 2'h0);
          if (ph_r == 2'h1) begin
            mshift_r <= {mshift_r[6:0], sda_in};
            bit_r <= bit_r + 4'h1;
            ph_r <= 2'h0;
          end
        end
        tw_pkg::M_SEND: if (bi.tick) begin
          mscl_r <= (ph_r == 2'h0);
          if (ph_r == 2'h1) begin
            bit_r <= bit_r + 4'h1;
            ph_r <= 2'h0;
            mshift_r <= {mshift_r[6:0], 1'b1};
            msda_r <= (bit_r == 4'h7) ? 1'b1 : mshift_r[6];
          end
        end
        default: mst_r <= tw_pkg::M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave address match
  // ----------------------------------------------------------------
  assign byte_in = receive_shift_reg;
  assign m_eff = ctrl_r[`B_ALL] ? 10'h000 : mask_r;
  assign gcall = (byte_in == 8'h00) & ctrl_r[`B_GCALL];
  assign reserved = (byte_in[7:1] == 7'h00 && (byte_in[0] || !ctrl_r[`B_GCALL]))
                  || (byte_in[7:4] == 4'h0 && byte_in[3:1] != 3'h0)
                  || (byte_in[7:3] == `PFX_RSV_HI);
  assign hit7 = !ctrl_r[`B_TEN] && byte_in[7:3] != `PFX_UPPER10
              && ((byte_in[7:1] ^ own_r[6:0]) & ~m_eff[6:0]) == 7'h00;
  assign hit_up = ctrl_r[`B_TEN] && byte_in[7:3] == `PFX_UPPER10
                && ((byte_in[2:1] ^ own_r[9:8]) & ~m_eff[9:8]) == 2'h0;
  assign hit_lo = ((byte_in ^ own_r[7:0]) & ~m_eff[7:0]) == 8'h00;
  assign ack_adr = !reserved && (ctrl_r[`B_ALL] || hit7 || hit_up || gcall);

  assign start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign rise = scl_in & ~scl_q_r;
  assign fall = ~scl_in & scl_q_r;

  // ----------------------------------------------------------------
  // Slave sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sl_r <= tw_pkg::S_IDLE;
      cnt_r <= '0;
      receive_shift_reg <= '0;
      sl_tx_r <= '0;
      sl_rw_r <= 1'b0;
      sl_hit10_r <= 1'b0;
      sl_data_r <= 1'b0;
      ack_drv_r <= 1'b0;
      rel_clr_r <= 1'b0;
      sl_ld_r <= 1'b0;
    end else if (!run) begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      rel_clr_r <= 1'b0;
      sl_ld_r <= 1'b0;
      if (!on) begin
        sl_r <= tw_pkg::S_IDLE;
        ack_drv_r <= 1'b0;
      end
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      rel_clr_r <= 1'b0;
      sl_ld_r <= 1'b0;
      if (stop_det) begin
        sl_r <= tw_pkg::S_IDLE;
        sl_hit10_r <= 1'b0;
        ack_drv_r <= 1'b0;
      end else if (start_det) begin
        sl_r <= tw_pkg::S_ADR1;
        cnt_r <= '0;
        ack_drv_r <= 1'b0;
      end else if (sl_r != tw_pkg::S_IDLE && rise) begin
        if (cnt_r < 4'h8) receive_shift_reg <= {receive_shift_reg[6:0], sda_in};
        if (cnt_r < 4'h9) cnt_r <= cnt_r + 4'h1;
        if (sl_r == tw_pkg::S_TXD && cnt_r == 4'h8 && sda_in) sl_r <= tw_pkg::S_IDLE;
      end else if (sl_r != tw_pkg::S_IDLE && fall) begin
        if (cnt_r == 4'h9) begin
          cnt_r <= '0;
          ack_drv_r <= 1'b0;
          if (sl_r == tw_pkg::S_TXD) begin
            rel_clr_r <= 1'b1;
            sl_tx_r <= txd_r;
          end
        end else if (cnt_r == 4'h8) begin
          unique case (sl_r)
            tw_pkg::S_ADR1: begin
              sl_rw_r <= byte_in[0];
              sl_data_r <= 1'b0;
              ack_drv_r <= ack_adr;
              if (!ack_adr) sl_r <= tw_pkg::S_IDLE;
              else if (hit_up && !byte_in[0]) sl_r <= tw_pkg::S_ADR2;
              else if (hit_up && !sl_hit10_r) sl_r <= tw_pkg::S_IDLE;
              else sl_r <= byte_in[0] ? tw_pkg::S_TXD : tw_pkg::S_RXD;
            end
            tw_pkg::S_ADR2: begin
              ack_drv_r <= hit_lo | ctrl_r[`B_ALL];
              sl_hit10_r <= hit_lo | ctrl_r[`B_ALL];
              sl_r <= (hit_lo | ctrl_r[`B_ALL]) ? tw_pkg::S_RXD : tw_pkg::S_IDLE;
            end
            tw_pkg::S_RXD: begin
              ack_drv_r <= 1'b1;
              sl_data_r <= 1'b1;
              sl_ld_r <= 1'b1;
              rel_clr_r <= ctrl_r[`B_STRETCH];
            end
            tw_pkg::S_TXD: sl_data_r <= 1'b1;
            default: sl_r <= tw_pkg::S_IDLE;
          endcase
        end else if (sl_r == tw_pkg::S_TXD && cnt_r != 4'h0) begin
          sl_tx_r <= {sl_tx_r[6:0], 1'b1};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      msda_d_r <= 1'b1;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      // Master data lags its clock by one cycle, so only Start, Repeated Start and Stop move it while the clock is high.
      msda_d_r <= msda_r;
      scl_oe <= on & (~mscl_r | (sl_r != tw_pkg::S_IDLE & ~ctrl_r[`B_REL]));
      sda_oe <= on & (~msda_d_r | ack_drv_r
                | (sl_r == tw_pkg::S_TXD & cnt_r < 4'h8 & ~sl_tx_r[7]));
    end
  end

endmodule : two_wire_ctrl

`default_nettype wire

// File: inc/tw_defs.svh
`ifndef TW_DEFS_SVH
`define TW_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_OWN 8'h08
`define OFS_MASK 8'h0C
`define OFS_RELOAD 8'h10
`define OFS_TXD 8'h14
`define OFS_RXD 8'h18

// ----------------------------------------------------------------
// Control bit positions and values
// ----------------------------------------------------------------
`define B_START 0
`define B_RSTART 1
`define B_STOP 2
`define B_RECV 3
`define B_ACKGO 4
`define B_ACKVAL 5
`define B_STRETCH 6
`define B_GCALL 7
`define B_TEN 10
`define B_ALL 11
`define B_REL 12
`define B_SIDL 13
`define B_ON 15
`define CTRL_RST 16'h1000
`define CTRL_WMASK 16'hBCFF

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define S_ACK 15
`define S_SEND 14
`define S_MBUSY 4
`define S_DATA 5
`define S_RW 2
`define S_FULL 1

// ----------------------------------------------------------------
// Address patterns and timing
// ----------------------------------------------------------------
`define PFX_UPPER10 5'h1E
`define PFX_RSV_HI 5'h1F
`define FCY_HZ 40000000
`define FIXED_DIV_HZ 10000000

`endif

// File: inc/tw_pkg.sv
package tw_pkg;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0,
    M_START = 3'h1,
    M_RSTART = 3'h3,
    M_STOP = 3'h2,
    M_RECV = 3'h6,
    M_ACK = 3'h7,
    M_SEND = 3'h5
  } mst_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADR1 = 3'h1,
    S_ADR2 = 3'h3,
    S_RXD = 3'h2,
    S_TXD = 3'h6
  } slv_t;

endpackage : tw_pkg

// File: inc/brg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface brg_if #(parameter int RW = 16);
  logic [RW-1:0] reload;
  logic run;
  logic tick;
  modport gen (input reload, input run, output tick);
  modport user (output reload, output run, input tick);
endinterface : brg_if

`default_nettype wire

// File: rtl/half_period_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"

module half_period_gen #(
  parameter int RW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  brg_if.gen bi
);

  localparam int EXTRA = `FCY_HZ / `FIXED_DIV_HZ;

  logic [RW:0] full;
  logic [RW-1:0] half;
  logic [RW-1:0] cnt_r;

  // Half of the full bit period, never below one cycle.
  assign full = {1'b0, bi.reload} + (RW+1)'(1 + EXTRA);
  assign half = (full[RW:1] == '0) ? RW'(1) : full[RW:1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      bi.tick <= 1'b0;
    end else if (!bi.run) begin
      cnt_r <= '0;
      bi.tick <= 1'b0;
    end else if (cnt_r <= RW'(1)) begin
      cnt_r <= half;
      bi.tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r - RW'(1);
      bi.tick <= 1'b0;
    end
  end

endmodule : half_period_gen

`default_nettype wire

// File: test/remote_slave.sv
`timescale 1ns/1ps
`default_nettype none

// ----
// Remote slave on the wire: acks its address, sends its byte in every byte of a read until Stop.
// ----
module remote_slave #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter logic [7:0] DATA = 8'h96
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_pull
);
  int n = -1;
  logic [7:0] sh = 8'h00;
  logic first = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  initial sda_pull = 1'b0;
  always @(negedge sda) if (scl) begin
    n = -1;
    first = 1'b1;
    rd = 1'b0;
  end
  always @(posedge sda) if (scl) sel = 1'b0;
  always @(posedge scl) sh = {sh[6:0], sda};
  always @(negedge scl) begin
    n = (n == 8) ? 0 : n + 1;
    if (n == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end
      sda_pull = first ? sel : (sel && !rd);
      first = 1'b0;
    end else if (sel && rd && n >= 0) sda_pull = !DATA[7-n];
    else sda_pull = 1'b0;
  end
endmodule : remote_slave

`default_nettype wire

// File: test/two_wire_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"

module two_wire_ctrl_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_idle,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic wr_c;
  logic on_r;
  logic sidl_r;
  assign wr_c = psel && penable && pready && pwrite && paddr == `OFS_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r <= 1'b0;
      sidl_r <= 1'b0;
    end else if (wr_c) begin
      on_r <= pwdata[`B_ON];
      sidl_r <= pwdata[`B_SIDL];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_wait: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("ready not a single pulse after access");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer without ready or with data");
  a_pins_odrain: assert property (!scl_out && !sda_out)
    else $error("pin output level not low");
  a_off_release: assert property (
    !on_r && !$past(on_r) |-> !scl_oe && !sda_oe)
    else $error("pins pulled while module off");
  a_idle_freeze: assert property (
    on_r && sidl_r && cpu_idle && $past(cpu_idle) && $past(cpu_idle, 2)
    |=> $stable(scl_oe) && $stable(sda_oe))
    else $error("bus moved while halted");
  a_start_cond: assert property (
    wr_c && pwdata[`B_ON] && pwdata[`B_START] |-> ##[1:100] $rose(sda_oe) && !scl_oe)
    else $error("no start condition");
  a_restart_cond: assert property (
    wr_c && pwdata[`B_ON] && pwdata[`B_RSTART] |-> ##[1:100] $rose(sda_oe) && !scl_oe)
    else $error("no repeated start condition");
  a_stop_cond: assert property (
    wr_c && pwdata[`B_ON] && pwdata[`B_STOP] |-> ##[1:100] $fell(sda_oe) && !scl_oe)
    else $error("no stop condition");
  a_nack_sent: assert property (
    wr_c && pwdata[`B_ON] && pwdata[`B_ACKGO] && pwdata[`B_ACKVAL] |=> !sda_oe [*8])
    else $error("data pulled during nack");
endmodule : two_wire_ctrl_checker

`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.svh"
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_fail++; \
  $display("mismatch %0t got %0h", $time, g); end end

module tb;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
  localparam logic [6:0] ADR = 7'h2A;
  localparam logic [7:0] DAT = 8'h96;
  localparam int R = 3;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cpu_idle = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, scl_oe, sda_oe, scl_out, sda_out, pull, e, last_b;
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || pull);
  int n_fail = 0, comparisons = 0, cyc = 0, t0 = 0, per = 0, n_st = 0, n_sp = 0;
  row_t rows [10] = '{'{8'h08, 32'hFFFFFFFF, 32'h3FF, 0}, '{8'h0C, 32'hFFFFFFFF, 32'h3FF, 0},
    '{8'h0C, 0, 0, 0}, '{8'h10, 32'hFFFFFFFF, 32'hFFFF, 0}, '{8'h10, R, R, 0},
    '{8'h1C, 32'hFFFFFFFF, 0, 1}, '{8'h00, 32'h1FC0, 32'h1CC0, 0},
    '{8'h00, 32'h0CC0, 32'h0CC0, 0}, '{8'h00, 32'h1000, 32'h1000, 0},
    '{8'h00, 0, 32'h1000, 0}};
  typedef struct {logic [15:0] c; logic [9:0] o; logic [9:0] m; logic [7:0] b;
    logic k;} adr_t;
  adr_t adrs [9] = '{'{16'h9001, 10'h013, 0, 8'h26, 0}, '{16'h9001, 10'h013, 10'h001, 8'h24, 0},
    '{16'h9001, 10'h013, 0, 8'h24, 1}, '{16'h9801, 10'h013, 0, 8'h6A, 0},
    '{16'h9001, 10'h013, 10'h3FF, 8'hF8, 1}, '{16'h9081, 10'h013, 0, 8'h00, 0},
    '{16'h9001, 10'h013, 0, 8'h00, 1}, '{16'h9401, 10'h2D3, 0, 8'hF4, 0},
    '{16'h9001, 10'h07A, 0, 8'hF4, 1}};
  always #12.5 pclk = ~pclk;
  two_wire_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_idle(cpu_idle), .scl_in(scl), .sda_in(sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));
  remote_slave #(.ADDR(ADR), .DATA(DAT)) slv (.scl(scl), .sda(sda), .sda_pull(pull));
  always @(negedge sda) if (scl) n_st++;
  always @(posedge sda) if (scl) n_sp++;
  always @(posedge scl) begin
    last_b = sda;
    per = cyc - t0;
    t0 = cyc;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_of_test;
    end
  end
  task automatic apb(input logic [7:0] a, input logic [31:0] w, input logic wr);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwdata <= w;
    pwrite <= wr;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic poll(input logic [7:0] a, input int b);
    do apb(a, 0, 0); while (r[b] !== 1'b0);
  endtask : poll
  task automatic txb(input logic [7:0] d);
    apb(`OFS_TXD, {24'h0, d}, 1);
    poll(`OFS_STAT, `S_SEND);
  endtask : txb
  task end_of_test;
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, 1);
      apb(rows[i].a, 0, 0);
      `CHK({r, e}, {rows[i].r, rows[i].e})
    end
    // Requests go one at a time in the usual read order.
    n_st = 0;
    n_sp = 0;
    apb(`OFS_CTRL, 32'h9001, 1);
    poll(`OFS_CTRL, `B_START);
    `CHK(n_st, 1)
    txb({ADR, 1'b0});
    `CHK(r[`S_ACK], 1'b0)
    `CHK(per, R + 5)
    apb(`OFS_CTRL, 32'h9002, 1);
    poll(`OFS_CTRL, `B_RSTART);
    `CHK(n_st, 2)
    txb({ADR, 1'b1});
    `CHK(r[`S_ACK], 1'b0)
    apb(`OFS_CTRL, 32'h9008, 1);
    poll(`OFS_CTRL, `B_RECV);
    apb(`OFS_RXD, 0, 0);
    `CHK(r[7:0], DAT)
    apb(`OFS_CTRL, 32'h9030, 1);
    poll(`OFS_CTRL, `B_ACKGO);
    `CHK(last_b, 1'b1)
    apb(`OFS_CTRL, 32'h9004, 1);
    poll(`OFS_CTRL, `B_STOP);
    `CHK(n_sp, 1)
    apb(`OFS_CTRL, 32'h9001, 1);
    poll(`OFS_CTRL, `B_START);
    txb({~ADR, 1'b0});
    `CHK(r[`S_ACK], 1'b1)
    apb(`OFS_CTRL, 32'h9004, 1);
    poll(`OFS_CTRL, `B_STOP);
    // The block's own slave answers the address byte sent by its own master.
    foreach (adrs[i]) begin
      apb(`OFS_OWN, {22'h0, adrs[i].o}, 1);
      apb(`OFS_MASK, {22'h0, adrs[i].m}, 1);
      apb(`OFS_CTRL, {16'h0, adrs[i].c}, 1);
      poll(`OFS_CTRL, `B_START);
      txb(adrs[i].b);
      `CHK(r[`S_ACK], adrs[i].k)
      apb(`OFS_CTRL, 32'h9004, 1);
      poll(`OFS_CTRL, `B_STOP);
    end
    cpu_idle <= 1;
    apb(`OFS_CTRL, 32'hB001, 1);
    repeat (40) @(posedge pclk);
    apb(`OFS_CTRL, 0, 0);
    `CHK(r[`B_START], 1'b1)
    cpu_idle <= 0;
    poll(`OFS_CTRL, `B_START);
    apb(`OFS_CTRL, 32'hB004, 1);
    poll(`OFS_CTRL, `B_STOP);
    apb(`OFS_CTRL, 0, 1);
    repeat (4) @(posedge pclk);
    `CHK({scl_oe, sda_oe}, 2'b00)
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(`OFS_CTRL, 0, 0);
    `CHK(r, 32'h0000_1000)
    apb(`OFS_MASK, 0, 0);
    `CHK(r, 32'h0000_0000)
    end_of_test;
  end
endmodule : tb

bind two_wire_ctrl two_wire_ctrl_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .scl_in(scl_in),
  .sda_in(sda_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

`default_nettype wire
